// *** hw/tcd_regs.svh ***
// Purpose: register map, field positions and reset values of the DMA block
// Assumes: classic Wishbone, 32-bit data, one aligned word per register
// Notes: channel c occupies byte offsets c*0x20 to c*0x20+0x1C
`ifndef TCD_REGS_SVH
`define TCD_REGS_SVH

// ************************************
// Register offsets within a channel
// ************************************
`define TCD_OFS_SEL  5'h00
`define TCD_OFS_CON  5'h04
`define TCD_OFS_SRC  5'h08
`define TCD_OFS_DST  5'h0C
`define TCD_OFS_RLD  5'h10
`define TCD_OFS_CNT  5'h14
`define TCD_OFS_PTR  5'h18

// ************************************
// Field positions
// ************************************
`define TCD_SEL_EXT  4
`define TCD_SEL_SW   5
`define TCD_CON_U8   0
`define TCD_CON_RPT  1
`define TCD_CON_PEND 2
`define TCD_CON_DDIR 3
`define TCD_CON_SDIR 4
`define TCD_CON_EN   5

// ************************************
// Codes and reset values
// ************************************
`define TCD_PIN_CODES 5'h04
`define TCD_RST_WORD  32'h0000_0000

`endif

// *** hw/tcd_pkg.sv ***
// Purpose: types shared by the DMA block
// Assumes: byte addresses of 20 bits
// Notes: none
package tcd_pkg;

  localparam int TCD_ADDR_W = 20;

  typedef enum logic [1:0] {
    TCD_IDLE = 2'b00,
    TCD_RD   = 2'b01,
    TCD_WR   = 2'b11,
    TCD_GAP  = 2'b10
  } tcd_state_e;

  typedef struct packed {
    logic                  stb;
    logic                  we;
    logic                  one_byte;
    logic [TCD_ADDR_W-1:0] addr;
    logic [15:0]           wdata;
  } tcd_mem_req_s;

endpackage

// *** hw/tcd_dma.sv ***
// Purpose: two-channel cycle-steal DMA controller
// Assumes: one clock; memory answers on the same clock
// Notes: registers reached over classic Wishbone
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "tcd_regs.svh"

module tcd_dma #(
  parameter int CNT_W = 16
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [31:0]           i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire logic [31:0]           i_wb_dat,
  output logic                       o_wb_ack,
  output logic [31:0]                o_wb_dat,
  input  wire logic                  i_ext_irq_pin_0,
  input  wire logic                  i_ext_irq_pin_1,
  input  wire logic [1:0][31:0]      i_irq_flag,
  output logic                       o_bus_req,
  input  wire logic                  i_bus_gnt,
  output tcd_pkg::tcd_mem_req_s      o_mem_req,
  input  wire logic                  i_mem_ack,
  input  wire logic [15:0]           i_mem_rdata,
  output logic [1:0]                 o_chan_irq
);

  localparam int AW = tcd_pkg::TCD_ADDR_W;

  // ************************************
  // Parameter check
  // ************************************
  if (CNT_W < 1 || CNT_W > 24) begin : g_chk
    $error("CNT_W out of range");
  end

  // ************************************
  // Declarations
  // ************************************
  tcd_pkg::tcd_state_e   st;
  tcd_pkg::tcd_state_e   next_st;
  tcd_pkg::tcd_mem_req_s next_mem;
  logic                  next_req;
  logic                  w_ch;
  logic                  w_u8;
  logic [AW-1:0]         w_src;
  logic [AW-1:0]         w_dst;
  logic                  part;
  logic [15:0]           w_data;
  logic [1:0]            pin_s1;
  logic [1:0]            pin_s2;
  logic [1:0]            pin_q;
  logic [1:0]            ch_go;
  logic [1:0]            ch_u8;
  logic [1:0][AW-1:0]    ch_src;
  logic [1:0][AW-1:0]    ch_dst;
  logic [1:0][31:0]      ch_rd;

  // ************************************
  // Bus slave decode
  // ************************************
  wire        wb_req  = i_wb_cyc & i_wb_stb;
  wire        wb_hit  = (i_wb_adr[31:6] == 26'h0) & (i_wb_adr[1:0] == 2'h0);
  wire        wb_wr   = wb_req & i_wb_we & o_wb_ack & wb_hit;
  wire        wb_ch   = i_wb_adr[5];
  wire [4:0]  wb_ofs  = i_wb_adr[4:0];
  wire [31:0] wb_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                         {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire        wb_rd   = wb_req & ~o_wb_ack & ~i_wb_we & wb_hit;
  wire [31:0] rd_word = wb_rd ? ch_rd[wb_ch] : `TCD_RST_WORD;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `TCD_RST_WORD;
    end else begin
      o_wb_ack <= wb_req & ~o_wb_ack;
      o_wb_dat <= rd_word;
    end
  end

  // ************************************
  // External pin synchroniser and edges
  // ************************************
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      pin_q  <= 2'h3;
    end else begin
      pin_s1 <= {i_ext_irq_pin_1, i_ext_irq_pin_0};
      pin_s2 <= pin_s1;
      pin_q  <= pin_s2;
    end
  end

  wire [3:0] pin_evt = {pin_q ^ pin_s2, pin_q & ~pin_s2};

  // ************************************
  // Engine control
  // ************************************
  wire          any_go   = |ch_go;
  wire          sel_ch   = ~ch_go[0];
  wire          start    = (st == tcd_pkg::TCD_IDLE) & o_bus_req & i_bus_gnt & any_go;
  wire [AW-1:0] base     = (st == tcd_pkg::TCD_WR) ? w_dst : w_src;
  wire          split    = ~w_u8 & base[0];
  wire          one_byte = w_u8 | split;
  wire [AW-1:0] ph_addr  = base + {{(AW-1){1'b0}}, part};
  wire          last     = ~split | part;
  wire          acked    = o_mem_req.stb & i_mem_ack;
  wire          fin      = acked & (st == tcd_pkg::TCD_WR) & last;
  wire          busy     = (st == tcd_pkg::TCD_RD) | (st == tcd_pkg::TCD_WR);
  wire          issue    = busy & ~o_mem_req.stb;
  wire [7:0]    wr_byte  = part ? w_data[15:8] : w_data[7:0];
  wire [15:0]   wdata    = one_byte ? {8'h00, wr_byte} : w_data;
  wire [15:0]   lo_data  = {w_data[15:8], i_mem_rdata[7:0]};
  wire [15:0]   hi_data  = {i_mem_rdata[7:0], w_data[7:0]};
  wire [15:0]   byte_dat = part ? hi_data : lo_data;
  wire [15:0]   rd_data  = one_byte ? byte_dat : i_mem_rdata;

  always_comb begin
    next_st = st;
    unique case (st)
      tcd_pkg::TCD_IDLE: if (start) next_st = tcd_pkg::TCD_RD;
      tcd_pkg::TCD_RD:   if (acked && last) next_st = tcd_pkg::TCD_WR;
      tcd_pkg::TCD_WR:   if (fin) next_st = tcd_pkg::TCD_GAP;
      tcd_pkg::TCD_GAP:  next_st = tcd_pkg::TCD_IDLE;
    endcase
  end

  // Hold the bus for one unit, then give it back for a cycle
  assign next_req = (next_st == tcd_pkg::TCD_RD) | (next_st == tcd_pkg::TCD_WR)
                  | ((next_st == tcd_pkg::TCD_IDLE) & any_go);

  assign next_mem = '{stb:      1'b1,
                      we:       (st == tcd_pkg::TCD_WR),
                      one_byte: one_byte,
                      addr:     ph_addr,
                      wdata:    wdata};

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st        <= tcd_pkg::TCD_IDLE;
      o_bus_req <= 1'b0;
      o_mem_req <= '0;
      w_ch      <= 1'b0;
      w_u8      <= 1'b0;
      w_src     <= '0;
      w_dst     <= '0;
      part      <= 1'b0;
      w_data    <= 16'h0000;
    end else begin
      st        <= next_st;
      o_bus_req <= next_req;
      if (start) begin
        w_ch  <= sel_ch;
        w_u8  <= ch_u8[sel_ch];
        w_src <= ch_src[sel_ch];
        w_dst <= ch_dst[sel_ch];
      end
      if (issue) begin
        o_mem_req <= next_mem;
      end
      if (acked) begin
        o_mem_req.stb <= 1'b0;
        part          <= ~last;
        if (st == tcd_pkg::TCD_RD) begin
          w_data <= rd_data;
        end
      end
    end
  end

  // ************************************
  // Channels
  // ************************************
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [4:0]       src_code;
    logic             en;
    logic             pend;
    logic             u8;
    logic             rpt;
    logic             ddir;
    logic             sdir;
    logic             first;
    logic             irq;
    logic [AW-1:0]    sar;
    logic [AW-1:0]    dar;
    logic [AW-1:0]    ptr;
    logic [CNT_W-1:0] rld;
    logic [CNT_W-1:0] cnt;
    logic [31:0]      flag_q;

    wire          me_w     = wb_wr & (wb_ch == 1'(c));
    wire          sel_w    = me_w & (wb_ofs == `TCD_OFS_SEL);
    wire          con_w    = me_w & (wb_ofs == `TCD_OFS_CON);
    wire          src_w    = me_w & (wb_ofs == `TCD_OFS_SRC);
    wire          dst_w    = me_w & (wb_ofs == `TCD_OFS_DST);
    wire          rld_w    = me_w & (wb_ofs == `TCD_OFS_RLD);
    wire [31:0]   con_word = {26'h0, en, sdir, ddir, pend, rpt, u8};
    wire [31:0]   cnt_word = {{(32-CNT_W){1'b0}}, cnt};
    wire [31:0]   rd_word  = (wb_ofs == `TCD_OFS_SEL) ? {27'h0, src_code} :
                             (wb_ofs == `TCD_OFS_CON) ? con_word :
                             (wb_ofs == `TCD_OFS_SRC) ? {12'h000, sar} :
                             (wb_ofs == `TCD_OFS_DST) ? {12'h000, dar} :
                             (wb_ofs == `TCD_OFS_RLD) ? {{(32-CNT_W){1'b0}}, rld} :
                             (wb_ofs == `TCD_OFS_CNT) ? cnt_word :
                             (wb_ofs == `TCD_OFS_PTR) ? {12'h000, ptr} :
                             `TCD_RST_WORD;
    wire [31:0]   wd       = (rd_word & ~wb_mask) | (i_wb_dat & wb_mask);

    // Flags are only watched, never written back
    wire [31:0]   flag_rise = i_irq_flag[c] & ~flag_q;
    wire          pin_sel   = src_code < `TCD_PIN_CODES;
    wire          evt       = pin_sel ? pin_evt[src_code[1:0]] : flag_rise[src_code];
    wire          sw_req    = sel_w & wd[`TCD_SEL_SW];
    wire          req       = evt | sw_req;
    wire          start_me  = start & (sel_ch == 1'(c));
    wire          fin_me    = fin & (w_ch == 1'(c));
    wire          uflow     = fin_me & (cnt == '0);
    wire          pend_clr  = start_me | (con_w & ~wd[`TCD_CON_PEND]);
    wire          next_pend = req | (pend & ~pend_clr);
    wire [AW-1:0] unit      = u8 ? 20'h00001 : 20'h00002;
    wire [AW-1:0] step_ptr  = ptr + unit;
    wire [AW-1:0] fwd_base  = sdir ? sar : dar;
    wire [AW-1:0] cur_ptr   = first ? fwd_base : ptr;

    assign ch_go[c]    = en & pend;
    assign ch_u8[c]    = u8;
    assign ch_src[c]   = sdir ? cur_ptr : sar;
    assign ch_dst[c]   = ddir ? cur_ptr : dar;
    assign ch_rd[c]    = rd_word;
    assign o_chan_irq[c] = irq;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        src_code <= 5'h00;
        en       <= 1'b0;
        pend     <= 1'b0;
        u8       <= 1'b0;
        rpt      <= 1'b0;
        ddir     <= 1'b0;
        sdir     <= 1'b0;
        first    <= 1'b0;
        irq      <= 1'b0;
        sar      <= '0;
        dar      <= '0;
        ptr      <= '0;
        rld      <= '0;
        cnt      <= '0;
        flag_q   <= 32'h0000_0000;
      end else begin
        flag_q <= i_irq_flag[c];
        pend   <= next_pend;
        irq    <= uflow;
        if (start_me && first) begin
          ptr   <= fwd_base;
          cnt   <= rld;
          first <= 1'b0;
        end
        if (fin_me) begin
          if (sdir || ddir) begin
            ptr <= step_ptr;
          end
          cnt <= (uflow & rpt) ? rld : cnt - 1'b1;
          if (uflow && !rpt) begin
            en <= 1'b0;
          end
        end
        if (sel_w) begin
          src_code <= wd[4:0];
        end
        if (con_w) begin
          en    <= wd[`TCD_CON_EN];
          first <= wd[`TCD_CON_EN];
          u8    <= wd[`TCD_CON_U8];
          rpt   <= wd[`TCD_CON_RPT];
          ddir  <= wd[`TCD_CON_DDIR];
          sdir  <= wd[`TCD_CON_SDIR];
        end
        if (src_w) begin
          sar <= wd[AW-1:0];
        end
        if (dst_w) begin
          dar <= wd[AW-1:0];
        end
        if (rld_w) begin
          rld <= wd[CNT_W-1:0];
        end
      end
    end
  end

endmodule // tcd_dma

// *** tb/tcd_dma_assertions.sv ***
// Purpose: port checks of tcd_dma
// Assumes: one clock domain
// Notes: bound to every tcd_dma
`timescale 1ns/10ps
module tcd_dma_chk (
  input wire logic                  i_clk_sys,
  input wire logic                  i_arst_n,
  input wire logic                  i_wb_cyc,
  input wire logic                  i_wb_stb,
  input wire logic                  i_wb_we,
  input wire logic [31:0]           i_wb_adr,
  input wire logic                  o_wb_ack,
  input wire logic [31:0]           o_wb_dat,
  input wire logic                  o_bus_req,
  input wire logic                  i_bus_gnt,
  input wire tcd_pkg::tcd_mem_req_s o_mem_req,
  input wire logic                  i_mem_ack,
  input wire logic [1:0]            o_chan_irq
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  wire logic wr_ack = o_mem_req.stb && o_mem_req.we && i_mem_ack;
  // Only the last byte of a split write ends a unit
  wire logic wr_last = wr_ack && (!o_mem_req.one_byte || !o_mem_req.addr[0]);
  wire logic wb_go = i_wb_cyc && i_wb_stb && !o_wb_ack;
  sequence s_wr_done; wr_last; endsequence
  sequence s_gap; !o_bus_req; endsequence
  a_ack_latency: assert property (wb_go |=> o_wb_ack) else $error("ack late");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("dat not 0");
  a_unmapped_zero: assert property (wb_go && !i_wb_we && i_wb_adr == 32'h1C |=> o_wb_dat == 32'h0)
    else $error("unmapped not 0");
  a_req_held: assert property (o_mem_req.stb && !i_mem_ack |=> o_mem_req.stb && $stable(o_mem_req))
    else $error("mem request moved");
  a_mem_granted: assert property (o_mem_req.stb |-> o_bus_req && i_bus_gnt)
    else $error("access without grant");
  a_gap_after_wr: assert property (s_wr_done |=> s_gap)
    else $error("no gap after write");
  a_irq_pulse: assert property (|o_chan_irq |=> o_chan_irq == 2'b00)
    else $error("irq too long");
  a_irq_cause: assert property (|o_chan_irq |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("irq without write");
endmodule // tcd_dma_chk
bind tcd_dma tcd_dma_chk u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_ack(o_wb_ack),
  .o_wb_dat(o_wb_dat), .o_bus_req(o_bus_req), .i_bus_gnt(i_bus_gnt), .o_mem_req(o_mem_req),
  .i_mem_ack(i_mem_ack), .o_chan_irq(o_chan_irq));

// *** tb/tcd_mem_model.sv ***
// Purpose: arbiter and memory beside tcd_dma
// Assumes: read word is derived from the address
// Notes: random wait before each ack
`timescale 1ns/10ps
module tcd_mem_model (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_bus_req,
  input  wire tcd_pkg::tcd_mem_req_s i_mem_req,
  output logic                       o_bus_gnt,
  output logic                       o_mem_ack,
  output logic [15:0]                o_mem_rdata
);
  logic [7:0] lf;
  logic [1:0] wait_cnt;
  wire logic [15:0] word = {~i_mem_req.addr[7:0], i_mem_req.addr[7:0]};
  // Inverse data outside the ack cycle
  assign o_mem_rdata = o_mem_ack ? word : ~word;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bus_gnt <= 1'b0;
      o_mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      lf <= 8'h5B;
    end else begin
      o_bus_gnt <= i_bus_req;
      lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      o_mem_ack <= 1'b0;
      if (i_mem_req.stb && !o_mem_ack) begin
        if (wait_cnt == 2'h0) begin
          o_mem_ack <= 1'b1;
          wait_cnt <= lf[1:0];
        end else begin
          wait_cnt <= wait_cnt - 2'h1;
        end
      end
    end
  end
endmodule // tcd_mem_model

// *** tb/tcd_dma_bench.sv ***
// Purpose: self-checking bench of tcd_dma
// Assumes: memory model with random waits
// Notes: writes checked from a queue of notes
`timescale 1ns/10ps
`include "tcd_regs.svh"
module tcd_dma_bench;
  logic clk, rst_n, cyc, stb, we, ack, gnt, mack, pin0, pin1, breq;
  logic [31:0] adr, dat, rdat, q;
  logic [1:0][31:0] flag;
  logic [15:0] mrd;
  logic [1:0] irq;
  tcd_pkg::tcd_mem_req_s mreq;
  logic [36:0] exp_q[$];
  logic [7:0] r, b;
  logic [19:0] s;
  int n_fail = 0, cmp_count = 0, n_irq0 = 0, n_irq1 = 0;
  tcd_dma u_dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_ack(ack),
    .o_wb_dat(rdat), .i_ext_irq_pin_0(pin0), .i_ext_irq_pin_1(pin1), .i_irq_flag(flag),
    .o_bus_req(breq), .i_bus_gnt(gnt), .o_mem_req(mreq), .i_mem_ack(mack),
    .i_mem_rdata(mrd), .o_chan_irq(irq));
  tcd_mem_model u_mem (.i_clk_sys(clk), .i_arst_n(rst_n), .i_bus_req(breq), .i_mem_req(mreq),
    .o_bus_gnt(gnt), .o_mem_ack(mack), .o_mem_rdata(mrd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic cmp(input string nm, input logic [36:0] e, input logic [36:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, 24'h0, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(nm, {5'h0, e}, {5'h0, q});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****
  // Write watcher
  // ****
  always @(posedge clk) begin
    n_irq0 += irq[0];
    n_irq1 += irq[1];
    if (mreq.stb && mreq.we && mack === 1'b1) begin
      cmp("write", exp_q.size() ? exp_q.pop_front() : 37'h0, {mreq.one_byte, mreq.addr,
        mreq.one_byte ? {8'h0, mreq.wdata[7:0]} : mreq.wdata});
    end
  end
  initial begin
    idle(6000);
    n_fail++;
    report_and_stop();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {cyc, stb, we, rst_n} = 4'h0;
    {adr, dat} = 64'h0;
    flag = 64'h0;
    {pin0, pin1} = 2'h3;
    r = 8'h14;
    idle(6);
    rst_n <= 1'b1;
    rd_chk("con reset", `TCD_OFS_CON, 32'h0);
    rd_chk("unmapped", 8'h1C, 32'h0);
    r = lfsr(r);
    s = {12'h123, r[7:1], 1'b0};
    wb(1, `TCD_OFS_SEL, 32'h04);
    wb(1, `TCD_OFS_SRC, {12'h0, s});
    wb(1, `TCD_OFS_DST, 32'h800);
    wb(1, `TCD_OFS_RLD, 32'h2);
    wb(1, `TCD_OFS_CON, 32'h30);
    for (int i = 0; i < 3; i++) begin
      b = s[7:0] + 8'(2 * i);
      exp_q.push_back({1'b0, 20'h800, ~b, b});
      wb(1, `TCD_OFS_SEL, 32'h24);
      idle(20);
    end
    cmp("irq0", 37'h1, 37'(n_irq0));
    rd_chk("con stop", `TCD_OFS_CON, 32'h10);
    rd_chk("ptr", `TCD_OFS_PTR, {12'h0, s + 20'h6});
    wb(1, `TCD_OFS_SEL, 32'h24);
    idle(10);
    rd_chk("con pend", `TCD_OFS_CON, 32'h14);
    wb(1, `TCD_OFS_CON, 32'h14);
    rd_chk("pend kept", `TCD_OFS_CON, 32'h14);
    wb(1, `TCD_OFS_CON, 32'h10);
    rd_chk("pend clear", `TCD_OFS_CON, 32'h10);
    wb(1, 8'h20, 32'h05);
    wb(1, 8'h28, 32'h333);
    wb(1, 8'h2C, 32'h900);
    wb(1, 8'h30, 32'h0);
    wb(1, 8'h24, 32'h2B);
    for (int i = 0; i < 2; i++) begin
      exp_q.push_back({1'b1, 20'h900 + 20'(i), 16'h33});
      flag[1][5] <= 1'b1;
      idle(3);
      flag[1][5] <= 1'b0;
      idle(20);
    end
    cmp("irq1", 37'h2, 37'(n_irq1));
    rd_chk("cnt1", 8'h34, 32'h0);
    r = lfsr(r);
    s = {12'h456, r[7:1], 1'b0};
    wb(1, `TCD_OFS_SRC, {12'h0, s});
    wb(1, `TCD_OFS_RLD, 32'h0);
    wb(1, `TCD_OFS_CON, 32'h30);
    exp_q.push_back({1'b0, 20'h800, ~s[7:0], s[7:0]});
    exp_q.push_back({1'b1, 20'h902, 16'h33});
    flag[0][4] <= 1'b1;
    flag[1][5] <= 1'b1;
    idle(40);
    flag <= '0;
    wb(1, `TCD_OFS_SEL, 32'h00);
    wb(1, `TCD_OFS_SRC, {12'h0, s + 20'h1});
    wb(1, `TCD_OFS_RLD, 32'h1);
    wb(1, `TCD_OFS_CON, 32'h30);
    b = s[7:0] + 8'h1;
    exp_q.push_back({1'b0, 20'h800, b + 8'h1, b});
    pin0 <= 1'b0;
    idle(30);
    pin0 <= 1'b1;
    idle(30);
    cmp("left", 37'h0, 37'(exp_q.size()));
    wb(1, `TCD_OFS_SEL, 32'h03);
    b = s[7:0] + 8'h3;
    exp_q.push_back({1'b0, 20'h800, b + 8'h1, b});
    pin1 <= 1'b0;
    idle(30);
    pin1 <= 1'b1;
    idle(30);
    rd_chk("con both", `TCD_OFS_CON, 32'h14);
    cmp("irq0 end", 37'h3, 37'(n_irq0));
    cmp("left end", 37'h0, 37'(exp_q.size()));
    report_and_stop();
  end
endmodule // tcd_dma_bench
